// ### verilog/iam_pkg.sv
// iam_pkg: constants and types for the ipv4 access_control_entry matcher
// assumes a single core clock; used by all iam design files
package iam_pkg;

	// =====================================================
	// register map (byte addresses)
	localparam logic [7:0] IAM_ADDR_CTRL = 8'h00;
	localparam logic [7:0] IAM_ADDR_PROTO = 8'h04;
	localparam logic [7:0] IAM_ADDR_SRC_IP = 8'h08;
	localparam logic [7:0] IAM_ADDR_SRC_MASK = 8'h0C;
	localparam logic [7:0] IAM_ADDR_DST_IP = 8'h10;
	localparam logic [7:0] IAM_ADDR_DST_MASK = 8'h14;
	localparam logic [7:0] IAM_ADDR_STATUS = 8'h18;
	localparam logic [7:0] IAM_ADDR_HIT_CNT = 8'h1C;
	localparam logic [7:0] IAM_ADDR_FRM_CNT = 8'h20;

	// =====================================================
	// widths
	localparam int IAM_AW = 8;
	localparam int IAM_DW = 32;
	localparam int IAM_CTRL_W = 14;
	localparam int IAM_FOFF_W = 13;

	// =====================================================
	// criterion codes
	localparam logic [2:0] IAM_PROTO_ANY = 3'h0;
	localparam logic [2:0] IAM_PROTO_SPECIFIC = 3'h1;
	localparam logic [2:0] IAM_PROTO_ICMP = 3'h2;
	localparam logic [2:0] IAM_PROTO_UDP = 3'h3;
	localparam logic [2:0] IAM_PROTO_TCP = 3'h4;
	// three-way criteria: ttl (no = zero, yes = non-zero), fragment, options
	localparam logic [1:0] IAM_TRI_ANY = 2'h0;
	localparam logic [1:0] IAM_TRI_NO = 2'h1;
	localparam logic [1:0] IAM_TRI_YES = 2'h2;
	// address criteria
	localparam logic [1:0] IAM_IP_ANY = 2'h0;
	localparam logic [1:0] IAM_IP_HOST = 2'h1;
	localparam logic [1:0] IAM_IP_NETWORK = 2'h2;

	// =====================================================
	// ip protocol numbers
	localparam logic [7:0] IAM_IPPROTO_ICMP = 8'h01;
	localparam logic [7:0] IAM_IPPROTO_TCP = 8'h06;
	localparam logic [7:0] IAM_IPPROTO_UDP = 8'h11;

	// =====================================================
	// control register layout, msb first
	typedef struct packed {
		logic [1:0] dstIpMode;
		logic [1:0] srcIpMode;
		logic [1:0] optMode;
		logic [1:0] fragMode;
		logic [1:0] ttlMode;
		logic [2:0] protoMode;
		logic frameIpv4;
	} iam_ctrl_t;

	localparam logic [IAM_CTRL_W-1:0] IAM_CTRL_RST = 14'h0000;
	localparam logic [7:0] IAM_PROTO_RST = 8'h00;
	localparam logic [31:0] IAM_WORD_RST = 32'h0000_0000;
	localparam logic [31:0] IAM_ONE = 32'h0000_0001;

endpackage : iam_pkg

// ### verilog/iam_tri_check.sv
// iam_tri_check: any / no / yes test of one frame property
// combinational; unknown code 3 acts as any
`timescale 1ns/1ps
module iam_tri_check (
	input wire logic [1:0] mode,
	input wire logic cond,
	output logic pass
);
	import iam_pkg::*;

	always_comb begin
		unique case (mode)
			IAM_TRI_NO: pass = !cond;
			IAM_TRI_YES: pass = cond;
			default: pass = 1'b1;
		endcase
	end

endmodule : iam_tri_check

// ### verilog/iam_ip_check.sv
// iam_ip_check: any / host / network test of one ipv4 address
// combinational; unknown code 3 acts as any
`timescale 1ns/1ps
module iam_ip_check (
	input wire logic [1:0] mode,
	input wire logic [31:0] frmAddr,
	input wire logic [31:0] cfgAddr,
	input wire logic [31:0] cfgMask,
	output logic pass
);
	import iam_pkg::*;

	always_comb begin
		unique case (mode)
			IAM_IP_HOST: pass = (frmAddr == cfgAddr);
			IAM_IP_NETWORK: pass = (((frmAddr ^ cfgAddr) & cfgMask) == IAM_WORD_RST);
			default: pass = 1'b1;
		endcase
	end

endmodule : iam_ip_check

// ### verilog/iam_matcher.sv
// iam_matcher: ipv4 criteria of one access_control_entry, with register port
// assumes frame fields come from the parser on core_clk, valid for one cycle
//
// Behaviour
// - ipv4 criteria apply only when the entry selects frame type ipv4
// - protocol any: protocol field ignored
// - protocol specific: hit only when 8-bit protocol equals configured value
// - protocol icmp: only icmp frames pass; icmp criteria become active
// - protocol udp: only udp frames pass; port criteria become active
// - protocol tcp: only tcp frames pass; port criteria become active
// - ttl zero: frames with ttl above zero miss
// - ttl non-zero: ttl above zero passes; ttl any ignores field
// - fragment no: more-fragments or nonzero offset misses
// - fragment yes: more-fragments or nonzero offset passes; any ignores
// - options no: frames with options present miss
// - options yes: options present passes; any ignores it
// - source host: exact 32-bit match; any ignores source
// - source network: only masked source bits compared
// - destination host: exact match; any ignores destination
// - destination network: only masked destination bits compared
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
module iam_matcher (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic [iam_pkg::IAM_AW-1:0] regAddr,
	input wire logic [iam_pkg::IAM_DW-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [iam_pkg::IAM_DW-1:0] regRdData,
	input wire logic frmValid,
	input wire logic frmIsIpv4,
	input wire logic [7:0] frmProto,
	input wire logic [7:0] frmTtl,
	input wire logic frmMoreFrag,
	input wire logic [iam_pkg::IAM_FOFF_W-1:0] frmFragOffset,
	input wire logic frmOptions,
	input wire logic [31:0] frmSrcIp,
	input wire logic [31:0] frmDstIp,
	output logic resValid,
	output logic resHit,
	output logic resIcmpActive,
	output logic resPortActive
);
	import iam_pkg::*;

	// =====================================================
	// state
	typedef struct packed {
		iam_ctrl_t ctrl;
		logic [7:0] protoVal;
		logic [31:0] srcIp;
		logic [31:0] srcMask;
		logic [31:0] dstIp;
		logic [31:0] dstMask;
		logic [31:0] hitCnt;
		logic [31:0] frmCnt;
		logic [IAM_DW-1:0] rdData;
		logic resValid;
		logic resHit;
		logic icmpActive;
		logic portActive;
		logic lastHit;
		logic lastIpv4;
		logic seenFrame;
	} iam_state_t;

	iam_state_t state_reg;
	iam_state_t state_next;

	// =====================================================
	// criterion checks
	logic protoPass;
	logic ttlPass;
	logic fragPass;
	logic optPass;
	logic srcPass;
	logic dstPass;
	logic typePass;
	logic allPass;
	logic fragPresent;
	logic ttlNonZero;
	logic icmpSel;
	logic portSel;

	assign fragPresent = frmMoreFrag || (frmFragOffset != '0);
	assign ttlNonZero = (frmTtl != 8'h00);

	// protocol selection
	always_comb begin
		protoPass = 1'b1;
		icmpSel = 1'b0;
		portSel = 1'b0;
		unique case (state_reg.ctrl.protoMode)
			IAM_PROTO_ANY: begin
				protoPass = 1'b1;
			end
			IAM_PROTO_SPECIFIC: begin
				protoPass = (frmProto == state_reg.protoVal);
			end
			IAM_PROTO_ICMP: begin
				protoPass = (frmProto == IAM_IPPROTO_ICMP);
				icmpSel = 1'b1;
			end
			IAM_PROTO_UDP: begin
				protoPass = (frmProto == IAM_IPPROTO_UDP);
				portSel = 1'b1;
			end
			IAM_PROTO_TCP: begin
				protoPass = (frmProto == IAM_IPPROTO_TCP);
				portSel = 1'b1;
			end
			default: begin
				protoPass = 1'b0;
			end
		endcase
	end

	iam_tri_check ttlCheck (
		.mode(state_reg.ctrl.ttlMode),
		.cond(ttlNonZero),
		.pass(ttlPass)
	);

	iam_tri_check fragCheck (
		.mode(state_reg.ctrl.fragMode),
		.cond(fragPresent),
		.pass(fragPass)
	);

	iam_tri_check optCheck (
		.mode(state_reg.ctrl.optMode),
		.cond(frmOptions),
		.pass(optPass)
	);

	iam_ip_check srcCheck (
		.mode(state_reg.ctrl.srcIpMode),
		.frmAddr(frmSrcIp),
		.cfgAddr(state_reg.srcIp),
		.cfgMask(state_reg.srcMask),
		.pass(srcPass)
	);

	iam_ip_check dstCheck (
		.mode(state_reg.ctrl.dstIpMode),
		.frmAddr(frmDstIp),
		.cfgAddr(state_reg.dstIp),
		.cfgMask(state_reg.dstMask),
		.pass(dstPass)
	);

	assign typePass = frmIsIpv4;

	assign allPass = state_reg.ctrl.frameIpv4 ?
		(typePass && protoPass && ttlPass && fragPass && optPass && srcPass && dstPass) :
		1'b1;

	// =====================================================
	// next state
	always_comb begin
		state_next = state_reg;
		state_next.resValid = 1'b0;
		state_next.rdData = IAM_WORD_RST;

		// frame result, one cycle after frmValid
		if (frmValid) begin
			state_next.resValid = 1'b1;
			state_next.resHit = allPass;
			// follow-on criteria only for ipv4 entries
			state_next.icmpActive = state_reg.ctrl.frameIpv4 && icmpSel;
			state_next.portActive = state_reg.ctrl.frameIpv4 && portSel;
			state_next.lastHit = allPass;
			state_next.lastIpv4 = frmIsIpv4;
			state_next.seenFrame = 1'b1;
		end

		// register writes
		if (regWr) begin
			unique case (regAddr)
				IAM_ADDR_CTRL: begin
					state_next.ctrl = iam_ctrl_t'(regWrData[IAM_CTRL_W-1:0]);
				end
				IAM_ADDR_PROTO: begin
					state_next.protoVal = regWrData[7:0];
				end
				IAM_ADDR_SRC_IP: begin
					state_next.srcIp = regWrData;
				end
				IAM_ADDR_SRC_MASK: begin
					state_next.srcMask = regWrData;
				end
				IAM_ADDR_DST_IP: begin
					state_next.dstIp = regWrData;
				end
				IAM_ADDR_DST_MASK: begin
					state_next.dstMask = regWrData;
				end
				IAM_ADDR_HIT_CNT: begin
					state_next.hitCnt = IAM_WORD_RST;
				end
				IAM_ADDR_FRM_CNT: begin
					state_next.frmCnt = IAM_WORD_RST;
				end
				IAM_ADDR_STATUS: begin
					state_next.seenFrame = frmValid;
				end
				default: begin
				end
			endcase
		end

		// counters; a frame in the clearing cycle still counts
		if (frmValid) begin
			if (regWr && (regAddr == IAM_ADDR_FRM_CNT)) begin
				state_next.frmCnt = IAM_ONE;
			end else begin
				state_next.frmCnt = state_reg.frmCnt + IAM_ONE;
			end
			if (allPass) begin
				if (regWr && (regAddr == IAM_ADDR_HIT_CNT)) begin
					state_next.hitCnt = IAM_ONE;
				end else begin
					state_next.hitCnt = state_reg.hitCnt + IAM_ONE;
				end
			end
		end

		// register reads
		if (regRd) begin
			unique case (regAddr)
				IAM_ADDR_CTRL: begin
					state_next.rdData = {{(IAM_DW-IAM_CTRL_W){1'b0}}, state_reg.ctrl};
				end
				IAM_ADDR_PROTO: begin
					state_next.rdData = {24'h00_0000, state_reg.protoVal};
				end
				IAM_ADDR_SRC_IP: begin
					state_next.rdData = state_reg.srcIp;
				end
				IAM_ADDR_SRC_MASK: begin
					state_next.rdData = state_reg.srcMask;
				end
				IAM_ADDR_DST_IP: begin
					state_next.rdData = state_reg.dstIp;
				end
				IAM_ADDR_DST_MASK: begin
					state_next.rdData = state_reg.dstMask;
				end
				IAM_ADDR_STATUS: begin
					state_next.rdData = {27'h000_0000, state_reg.portActive,
						state_reg.icmpActive, state_reg.lastIpv4,
						state_reg.lastHit, state_reg.seenFrame};
				end
				IAM_ADDR_HIT_CNT: begin
					state_next.rdData = state_reg.hitCnt;
				end
				IAM_ADDR_FRM_CNT: begin
					state_next.rdData = state_reg.frmCnt;
				end
				default: begin
					state_next.rdData = IAM_WORD_RST;
				end
			endcase
		end
	end

	// =====================================================
	// state register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg.ctrl <= iam_ctrl_t'(IAM_CTRL_RST);
			state_reg.protoVal <= IAM_PROTO_RST;
			state_reg.srcIp <= IAM_WORD_RST;
			state_reg.srcMask <= IAM_WORD_RST;
			state_reg.dstIp <= IAM_WORD_RST;
			state_reg.dstMask <= IAM_WORD_RST;
			state_reg.hitCnt <= IAM_WORD_RST;
			state_reg.frmCnt <= IAM_WORD_RST;
			state_reg.rdData <= IAM_WORD_RST;
			state_reg.resValid <= 1'b0;
			state_reg.resHit <= 1'b0;
			state_reg.icmpActive <= 1'b0;
			state_reg.portActive <= 1'b0;
			state_reg.lastHit <= 1'b0;
			state_reg.lastIpv4 <= 1'b0;
			state_reg.seenFrame <= 1'b0;
		end else if (clkEn) begin
			state_reg <= state_next;
		end
	end

	// =====================================================
	// outputs
	assign regRdData = state_reg.rdData;
	assign resValid = state_reg.resValid;
	assign resHit = state_reg.resHit;
	assign resIcmpActive = state_reg.icmpActive;
	assign resPortActive = state_reg.portActive;

endmodule : iam_matcher

// ### sim/iam_matcher_assertions.sv
// iam_matcher_assertions: result timing and forced-miss checks
// assumes bound to iam_matcher; sees its ports only
`timescale 1ns/1ps
module iam_matcher_assertions (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic [iam_pkg::IAM_AW-1:0] regAddr,
	input wire logic [iam_pkg::IAM_DW-1:0] regWrData,
	input wire logic regWr,
	input wire logic frmValid,
	input wire logic frmIsIpv4,
	input wire logic [7:0] frmTtl,
	input wire logic frmMoreFrag,
	input wire logic [iam_pkg::IAM_FOFF_W-1:0] frmFragOffset,
	input wire logic frmOptions,
	input wire logic resValid,
	input wire logic resHit,
	input wire logic resIcmpActive,
	input wire logic resPortActive
);
	import iam_pkg::*;
	iam_ctrl_t ctrl_reg;
	logic fire;
	logic ip;
	assign fire = frmValid && clkEn;
	assign ip = fire && ctrl_reg.frameIpv4;
	// ==========
	// control word shadow
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= iam_ctrl_t'(IAM_CTRL_RST);
		end else if (clkEn && regWr && regAddr == IAM_ADDR_CTRL) begin
			ctrl_reg <= iam_ctrl_t'(regWrData[IAM_CTRL_W-1:0]);
		end
	end
	// ==========
	// properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	result_pulse_a: assert property (fire |=> resValid)
		else $error("no result after frame");
	no_stray_a: assert property (clkEn && !frmValid |=> !resValid)
		else $error("result without frame");
	entry_off_a: assert property (
		fire && !ctrl_reg.frameIpv4 |=> resHit && !resIcmpActive && !resPortActive)
		else $error("entry without ipv4 must hit");
	wrong_type_a: assert property (ip && !frmIsIpv4 |=> !resHit)
		else $error("non ipv4 frame hit");
	ttl_zero_a: assert property (
		ip && ctrl_reg.ttlMode == IAM_TRI_NO && frmTtl != 8'h00 |=> !resHit)
		else $error("ttl above zero hit");
	frag_no_a: assert property (ip && ctrl_reg.fragMode == IAM_TRI_NO
		&& (frmMoreFrag || frmFragOffset != '0) |=> !resHit)
		else $error("fragment hit");
	opt_no_a: assert property (
		ip && ctrl_reg.optMode == IAM_TRI_NO && frmOptions |=> !resHit)
		else $error("options hit");
	icmp_active_a: assert property (
		ip && ctrl_reg.protoMode == IAM_PROTO_ICMP |=> resIcmpActive && !resPortActive)
		else $error("icmp criteria flag wrong");
	port_active_a: assert property (ip && (ctrl_reg.protoMode == IAM_PROTO_UDP
		|| ctrl_reg.protoMode == IAM_PROTO_TCP) |=> resPortActive && !resIcmpActive)
		else $error("port criteria flag wrong");
	cover property (ip |=> resHit);
	cover property (ip |=> !resHit);
	cover property (ip && ctrl_reg.protoMode == IAM_PROTO_TCP);
endmodule : iam_matcher_assertions

bind iam_matcher iam_matcher_assertions i_iam_matcher_assertions (.core_clk(core_clk),
	.reset_n(reset_n), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .frmValid(frmValid), .frmIsIpv4(frmIsIpv4), .frmTtl(frmTtl),
	.frmMoreFrag(frmMoreFrag), .frmFragOffset(frmFragOffset), .frmOptions(frmOptions),
	.resValid(resValid), .resHit(resHit), .resIcmpActive(resIcmpActive),
	.resPortActive(resPortActive));

// ### sim/iam_frame_src.sv
// iam_frame_src: header source standing in for the frame parser
// assumes shared core_clk; fields are zero before the first frame, then hold the inverted last header between frames
`timescale 1ns/1ps
module iam_frame_src (
	input wire logic core_clk,
	output logic frmValid,
	output logic frmIsIpv4,
	output logic [7:0] frmProto,
	output logic [7:0] frmTtl,
	output logic frmMoreFrag,
	output logic [iam_pkg::IAM_FOFF_W-1:0] frmFragOffset,
	output logic frmOptions,
	output logic [31:0] frmSrcIp,
	output logic [31:0] frmDstIp
);
	import iam_pkg::*;
	logic [95:0] flds = '0;
	assign {frmIsIpv4, frmProto, frmTtl, frmMoreFrag, frmFragOffset, frmOptions, frmSrcIp,
		frmDstIp} = flds;
	initial frmValid = 1'b0;
	// one header pulse after gap idle cycles
	task automatic send(input logic [95:0] f, input int gap);
		repeat (gap) @(posedge core_clk);
		@(posedge core_clk);
		frmValid <= 1'b1;
		flds <= f;
		@(posedge core_clk);
		frmValid <= 1'b0;
		flds <= ~f;
	endtask : send
endmodule : iam_frame_src

// ### sim/tb_iam_matcher.sv
// tb_iam_matcher: directed checks of the ipv4 entry matcher
// assumes iam_pkg, iam_matcher and iam_frame_src compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_iam_matcher;
	import iam_pkg::*;
	logic core_clk, reset_n, clkEn, regWr, regRd, resValid, resHit, resIcmpActive;
	logic resPortActive, frmValid, frmIsIpv4, frmMoreFrag, frmOptions, v4, mf, op;
	logic [7:0] regAddr, frmProto, frmTtl, pr, tt;
	logic [31:0] regWrData, regRdData, frmSrcIp, frmDstIp, sa, da;
	logic [12:0] frmFragOffset, of;
	int fail_count = 0, num_checks = 0, cycles = 0, gap = 0;
	iam_matcher i_iam_matcher (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .frmValid(frmValid), .frmIsIpv4(frmIsIpv4),
		.frmProto(frmProto), .frmTtl(frmTtl), .frmMoreFrag(frmMoreFrag),
		.frmFragOffset(frmFragOffset), .frmOptions(frmOptions), .frmSrcIp(frmSrcIp),
		.frmDstIp(frmDstIp), .resValid(resValid), .resHit(resHit),
		.resIcmpActive(resIcmpActive), .resPortActive(resPortActive));
	iam_frame_src i_iam_frame_src (.core_clk(core_clk), .frmValid(frmValid),
		.frmIsIpv4(frmIsIpv4), .frmProto(frmProto), .frmTtl(frmTtl),
		.frmMoreFrag(frmMoreFrag), .frmFragOffset(frmFragOffset), .frmOptions(frmOptions),
		.frmSrcIp(frmSrcIp), .frmDstIp(frmDstIp));
	// ==========
	// bus and frame tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 `CHK(regRdData, e)
	endtask : rd
	task automatic frm(input logic h, input logic [1:0] act);
		i_iam_frame_src.send({v4, pr, tt, mf, of, op, sa, da}, gap);
		#1 `CHK({resValid, resHit, resIcmpActive, resPortActive}, {1'b1, h, act})
	endtask : frm
	// ==========
	// scenarios
	task automatic t_reset;
		rd(IAM_ADDR_CTRL, '0);
		rd(8'h24, '0);
		frm(1'b1, 2'b00);
	endtask : t_reset
	task automatic t_proto;
		logic [7:0] fp [4] = '{IAM_IPPROTO_ICMP, IAM_IPPROTO_UDP, IAM_IPPROTO_TCP, 8'hFF};
		logic e;
		wr(IAM_ADDR_PROTO, 32'h0000_00FF);
		for (int m = 0; m < 5; m++) begin
			wr(IAM_ADDR_CTRL, {28'h0, m[2:0], 1'b1});
			for (int k = 0; k < 4; k++) begin
				pr = fp[k];
				e = m == 0 || (m == 1 && k == 3) || m == k + 2;
				frm(e, {m == 2, m > 2});
			end
		end
	endtask : t_proto
	task automatic t_tri;
		logic [1:0] md [3] = '{IAM_TRI_ANY, IAM_TRI_NO, IAM_TRI_YES};
		logic e;
		for (int f = 0; f < 3; f++) begin
			for (int j = 0; j < 3; j++) begin
				wr(IAM_ADDR_CTRL, IAM_ONE | (32'(md[j]) << (4 + 2 * f)));
				for (int c = 0; c < 3; c++) begin
					tt = 8'(c);
					of = 13'(c == 1);
					mf = (c == 2);
					op = (c != 0);
					e = md[j] == IAM_TRI_ANY || ((md[j] == IAM_TRI_YES) == (c != 0));
					frm(e, 2'b00);
				end
			end
		end
	endtask : t_tri
	task automatic t_addr;
		logic [31:0] fa [3] = '{32'hC0A8_0100, 32'hC0A8_01FF, 32'hC0A9_0100};
		logic [1:0] im [3] = '{IAM_IP_ANY, IAM_IP_HOST, IAM_IP_NETWORK};
		logic e;
		wr(IAM_ADDR_SRC_IP, fa[0]);
		wr(IAM_ADDR_SRC_MASK, 32'hFFFF_FF00);
		wr(IAM_ADDR_DST_IP, fa[0]);
		wr(IAM_ADDR_DST_MASK, 32'hFFFF_FF00);
		gap = 2;
		for (int s = 0; s < 2; s++) begin
			for (int j = 0; j < 3; j++) begin
				wr(IAM_ADDR_CTRL, IAM_ONE | (32'(im[j]) << (10 + 2 * s)));
				for (int k = 0; k < 3; k++) begin
					sa = (s == 0) ? fa[k] : 32'h0000_0000;
					da = (s == 1) ? fa[k] : 32'h0000_0000;
					e = j == 0 || k == 0 || (j == 2 && k == 1);
					frm(e, 2'b00);
				end
			end
		end
		wr(IAM_ADDR_CTRL, 32'h0000_1401);
		sa = fa[0];
		frm(1'b0, 2'b00);
		da = fa[0];
		frm(1'b1, 2'b00);
		v4 = 1'b0;
		frm(1'b0, 2'b00);
	endtask : t_addr
	// register readback, status, counters and clock enable freeze
	task automatic t_regs;
		rd(IAM_ADDR_PROTO, 32'h0000_00FF);
		rd(IAM_ADDR_SRC_MASK, 32'hFFFF_FF00);
		rd(IAM_ADDR_CTRL, 32'h0000_1401);
		rd(IAM_ADDR_STATUS, 32'h0000_0001);
		wr(IAM_ADDR_HIT_CNT, '0);
		wr(IAM_ADDR_FRM_CNT, '0);
		wr(IAM_ADDR_STATUS, '0);
		rd(IAM_ADDR_STATUS, '0);
		rd(IAM_ADDR_FRM_CNT, '0);
		v4 = 1'b1;
		frm(1'b1, 2'b00);
		rd(IAM_ADDR_STATUS, 32'h0000_0007);
		rd(IAM_ADDR_HIT_CNT, IAM_ONE);
		@(posedge core_clk);
		clkEn <= 1'b0;
		i_iam_frame_src.send({v4, pr, tt, mf, of, op, sa, da}, 0);
		#1 `CHK(resValid, 1'b0)
		@(posedge core_clk);
		clkEn <= 1'b1;
		rd(IAM_ADDR_FRM_CNT, IAM_ONE);
	endtask : t_regs
	// ==========
	// clock, watchdog, sequence
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test
	initial begin
		{reset_n, regWr, regRd, regAddr, regWrData, mf, op, of, sa, da} = '0;
		{clkEn, v4, pr, tt} = {1'b1, 1'b1, IAM_IPPROTO_TCP, 8'h01};
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset();
		t_proto();
		t_tri();
		t_addr();
		t_regs();
		finish_test();
	end
endmodule : tb_iam_matcher
